// file: rtl/rtc_calendar.v
`include "rtc_defines.vh"
`default_nettype none

module rtc_calendar (
    input wire mclk,
    input wire rst,
    input wire osc_1hz,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    output reg time_frozen
);
    reg scl_meta;
    reg scl_s;
    reg sda_meta;
    reg sda_s;
    reg osc_meta;
    reg osc_s;
    reg osc_d;

    reg integrity_lost_flag;
    reg [7:0] sec;
    reg [7:0] min;
    reg [7:0] hour;
    reg [7:0] day;
    reg [7:0] wday;
    reg [7:0] mon;
    reg cent;
    reg [7:0] year;
    reg tick_pending;

    reg next_integrity_lost_flag;
    reg [7:0] next_sec;
    reg [7:0] next_min;
    reg [7:0] next_hour;
    reg [7:0] next_day;
    reg [7:0] next_wday;
    reg [7:0] next_mon;
    reg next_cent;
    reg [7:0] next_year;
    reg [7:0] rd_data;

    wire [3:0] reg_ptr;
    wire [3:0] wr_addr;
    wire [7:0] wr_data;
    wire wr_stb;
    wire busy;

    // Only one edge per oscillator period is taken, so a wide tick pulse
    // from the slow domain still counts as a single second.
    wire tick = osc_s & ~osc_d;
    wire advance = (tick | tick_pending) & ~busy;

    // The pin only ever pulls low; release lets the bus pull-up win.
    assign sda_out = 1'b0;

    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == `RTC_UNIT_NINE) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // A two-digit BCD year is a multiple of four when an even tens digit
    // meets units 0, 4 or 8, or an odd tens digit meets units 2 or 6.
    function leap_year;
        input [7:0] y;
        begin
            if (y[4] == 1'b0) begin
                leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
            end else begin
                leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
            end
        end
    endfunction

    function [7:0] last_day;
        input [7:0] m;
        input [7:0] y;
        begin
            if (m == `RTC_FEB) begin
                last_day = leap_year(y) ? `RTC_DAYS_29 : `RTC_DAYS_28;
            end else if (m == `RTC_APR || m == `RTC_JUN || m == `RTC_SEP
                         || m == `RTC_NOV) begin
                last_day = `RTC_DAYS_30;
            end else begin
                last_day = `RTC_DAYS_31;
            end
        end
    endfunction

    always @(posedge mclk) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            osc_meta <= 1'b0;
            osc_s <= 1'b0;
            osc_d <= 1'b0;
        end else begin
            scl_meta <= scl_in;
            scl_s <= scl_meta;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
            osc_meta <= osc_1hz;
            osc_s <= osc_meta;
            osc_d <= osc_s;
        end
    end

    rtc_i2c_port #(
        .DEV_ADDR(`RTC_I2C_ADDR)
    ) u_port (
        .mclk(mclk),
        .rst(rst),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .rd_data(rd_data),
        .reg_ptr(reg_ptr),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_stb(wr_stb),
        .busy(busy),
        .sda_oe_n(sda_oe_n)
    );

    // Registers outside the time and date set read as zero here.
    always @* begin
        case (reg_ptr)
            `RTC_REG_SEC: rd_data = {integrity_lost_flag, sec[6:0]};
            `RTC_REG_MIN: rd_data = min & `RTC_MIN_MASK;
            `RTC_REG_HOUR: rd_data = hour & `RTC_HOUR_MASK;
            `RTC_REG_DAY: rd_data = day & `RTC_DAY_MASK;
            `RTC_REG_WDAY: rd_data = wday & `RTC_WDAY_MASK;
            `RTC_REG_MON: rd_data = {cent, mon[6:0]};
            `RTC_REG_YEAR: rd_data = year & `RTC_YEAR_MASK;
            default: rd_data = 8'h00;
        endcase
    end

    always @* begin
        next_integrity_lost_flag = integrity_lost_flag;
        next_sec = sec;
        next_min = min;
        next_hour = hour;
        next_day = day;
        next_wday = wday;
        next_mon = mon;
        next_cent = cent;
        next_year = year;
        if (advance) begin
            if (sec == `RTC_SEC_MAX) begin
                next_sec = `RTC_ZERO;
                if (min == `RTC_MIN_MAX) begin
                    next_min = `RTC_ZERO;
                    if (hour == `RTC_HOUR_MAX) begin
                        next_hour = `RTC_ZERO;
                        if (wday == `RTC_WDAY_MAX) begin
                            next_wday = `RTC_ZERO;
                        end else begin
                            next_wday = wday + 8'h01;
                        end
                        if (day == last_day(mon, year)) begin
                            next_day = `RTC_FIRST;
                            if (mon == `RTC_MON_MAX) begin
                                next_mon = `RTC_FIRST;
                                if (year == `RTC_YEAR_MAX) begin
                                    next_year = `RTC_ZERO;
                                    next_cent = ~cent;
                                end else begin
                                    next_year = bcd_inc(year);
                                end
                            end else begin
                                next_mon = bcd_inc(mon);
                            end
                        end else begin
                            next_day = bcd_inc(day);
                        end
                    end else begin
                        next_hour = bcd_inc(hour);
                    end
                end else begin
                    next_min = bcd_inc(min);
                end
            end else begin
                next_sec = bcd_inc(sec);
            end
        end
        // Writes only happen while the counters are frozen, so they never
        // collide with an increment in the same cycle.
        if (wr_stb) begin
            case (wr_addr)
                `RTC_REG_SEC: begin
                    next_integrity_lost_flag = wr_data[`RTC_LOST_BIT];
                    next_sec = wr_data & `RTC_SEC_MASK;
                end
                `RTC_REG_MIN: next_min = wr_data & `RTC_MIN_MASK;
                `RTC_REG_HOUR: next_hour = wr_data & `RTC_HOUR_MASK;
                `RTC_REG_DAY: next_day = wr_data & `RTC_DAY_MASK;
                `RTC_REG_WDAY: next_wday = wr_data & `RTC_WDAY_MASK;
                `RTC_REG_MON: begin
                    next_cent = wr_data[`RTC_CENT_BIT];
                    next_mon = wr_data & `RTC_MON_MASK;
                end
                `RTC_REG_YEAR: next_year = wr_data & `RTC_YEAR_MASK;
                default: next_sec = next_sec;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            integrity_lost_flag <= `RTC_RST_LOST;
            sec <= `RTC_RST_TIME;
            min <= `RTC_RST_TIME;
            hour <= `RTC_RST_TIME;
            day <= `RTC_RST_DATE;
            wday <= `RTC_RST_TIME;
            mon <= `RTC_RST_DATE;
            cent <= `RTC_RST_CENT;
            year <= `RTC_RST_TIME;
            tick_pending <= 1'b0;
            time_frozen <= 1'b0;
        end else begin
            integrity_lost_flag <= next_integrity_lost_flag;
            sec <= next_sec;
            min <= next_min;
            hour <= next_hour;
            day <= next_day;
            wday <= next_wday;
            mon <= next_mon;
            cent <= next_cent;
            year <= next_year;
            time_frozen <= busy;
            // A tick during the freeze is held, and only one is kept: an
            // access longer than a second loses the extra seconds.
            if (tick & busy) begin
                tick_pending <= 1'b1;
            end else if (advance) begin
                tick_pending <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// file: rtl/rtc_defines.vh
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Seven-bit bus address; the read and write forms are A3h and A2h.
`define RTC_I2C_ADDR 7'h51

// Register offsets, as seen through the byte pointer.
`define RTC_REG_SEC 4'h2
`define RTC_REG_MIN 4'h3
`define RTC_REG_HOUR 4'h4
`define RTC_REG_DAY 4'h5
`define RTC_REG_WDAY 4'h6
`define RTC_REG_MON 4'h7
`define RTC_REG_YEAR 4'h8

// Field layout.
`define RTC_LOST_BIT 7
`define RTC_CENT_BIT 7
`define RTC_SEC_MASK 8'h7F
`define RTC_MIN_MASK 8'h7F
`define RTC_HOUR_MASK 8'h3F
`define RTC_DAY_MASK 8'h3F
`define RTC_WDAY_MASK 8'h07
`define RTC_MON_MASK 8'h1F
`define RTC_YEAR_MASK 8'hFF

// Counter limits and calendar constants, in BCD.
`define RTC_SEC_MAX 8'h59
`define RTC_MIN_MAX 8'h59
`define RTC_HOUR_MAX 8'h23
`define RTC_WDAY_MAX 8'h06
`define RTC_MON_MAX 8'h12
`define RTC_YEAR_MAX 8'h99
`define RTC_ZERO 8'h00
`define RTC_FIRST 8'h01
`define RTC_FEB 8'h02
`define RTC_APR 8'h04
`define RTC_JUN 8'h06
`define RTC_SEP 8'h09
`define RTC_NOV 8'h11
`define RTC_DAYS_28 8'h28
`define RTC_DAYS_29 8'h29
`define RTC_DAYS_30 8'h30
`define RTC_DAYS_31 8'h31
`define RTC_UNIT_NINE 4'h9

// Reset values applied by the rst input.
`define RTC_RST_LOST 1'b1
`define RTC_RST_TIME 8'h00
`define RTC_RST_DATE 8'h01
`define RTC_RST_CENT 1'b0

// Bit counter limits in the serial port.
`define RTC_BITS_BYTE 4'h8
`define RTC_BITS_LAST 4'h7

`endif

// file: rtl/rtc_i2c_port.v
`include "rtc_defines.vh"
`default_nettype none

module rtc_i2c_port #(
    parameter [6:0] DEV_ADDR = `RTC_I2C_ADDR
) (
    input wire mclk,
    input wire rst,
    input wire scl_s,
    input wire sda_s,
    input wire [7:0] rd_data,
    output reg [3:0] reg_ptr,
    output reg [3:0] wr_addr,
    output reg [7:0] wr_data,
    output reg wr_stb,
    output reg busy,
    output reg sda_oe_n
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_WBYTE = 6'h08;
    localparam [5:0] ST_RBYTE = 6'h10;
    localparam [5:0] ST_MACK = 6'h20;

    reg [5:0] state;
    reg [7:0] shreg;
    reg [3:0] bitcnt;
    reg scl_d;
    reg sda_d;
    reg rw;
    reg ptr_phase;
    reg nack;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            rw <= 1'b0;
            ptr_phase <= 1'b0;
            nack <= 1'b0;
            reg_ptr <= 4'h0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            wr_stb <= 1'b0;
            busy <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            wr_stb <= 1'b0;
            if (bus_stop) begin
                state <= ST_IDLE;
                busy <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (bus_start) begin
                // A repeated start keeps the freeze so a pointer write and
                // the following burst read stay one consistent snapshot.
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == `RTC_BITS_BYTE) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                state <= ST_ACK;
                                sda_oe_n <= 1'b0;
                                rw <= shreg[0];
                                ptr_phase <= ~shreg[0];
                                busy <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                                busy <= 1'b0;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (rw) begin
                                shreg <= rd_data;
                                sda_oe_n <= rd_data[7];
                                state <= ST_RBYTE;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= ST_WBYTE;
                            end
                        end
                    end
                    ST_WBYTE: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == `RTC_BITS_BYTE) begin
                            if (ptr_phase) begin
                                reg_ptr <= shreg[3:0];
                                ptr_phase <= 1'b0;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_addr <= reg_ptr;
                                wr_data <= shreg;
                                reg_ptr <= reg_ptr + 4'h1;
                            end
                            state <= ST_ACK;
                            sda_oe_n <= 1'b0;
                        end
                    end
                    ST_RBYTE: begin
                        if (scl_fall) begin
                            if (bitcnt == `RTC_BITS_LAST) begin
                                sda_oe_n <= 1'b1;
                                reg_ptr <= reg_ptr + 4'h1;
                                state <= ST_MACK;
                            end else begin
                                shreg <= {shreg[6:0], 1'b0};
                                sda_oe_n <= shreg[6];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            nack <= sda_s;
                        end else if (scl_fall) begin
                            if (nack) begin
                                state <= ST_IDLE;
                            end else begin
                                shreg <= rd_data;
                                sda_oe_n <= rd_data[7];
                                bitcnt <= 4'h0;
                                state <= ST_RBYTE;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// file: testbench/rtc_calendar_checker.sv
`default_nettype none
module rtc_calendar_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic osc_1hz,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic time_frozen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] stop_age;
    logic [6:0] low_run;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // An address acknowledge followed by a read byte of zeros keeps SDA low for nine
    // bit times; anything longer is a stuck driver.
    always @(posedge mclk) begin
        if (rst) stop_age <= 4'hF;
        else if (scl_in && $rose(sda_in)) stop_age <= 4'h0;
        else if (stop_age != 4'hF) stop_age <= stop_age + 4'h1;
        low_run <= (rst || sda_oe_n) ? 7'h00 : low_run + 7'h01;
    end
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    sequence thaw;
        ##[1:8] !time_frozen;
    endsequence
    a_out_tied_low: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_reset_idle: assert property ($fell(rst) |-> sda_oe_n && !time_frozen)
        else $error("outputs not idle after reset");
    a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("sda driven while scl high");
    a_drop_scl_low: assert property ($rose(sda_oe_n) && !$past(rst) |-> !scl_in)
        else $error("sda released while scl high");
    a_freeze_in_ack: assert property ($rose(time_frozen) |-> !sda_oe_n)
        else $error("freeze began outside address ack");
    a_thaw_on_stop: assert property (time_frozen ##0 stop_seen |-> thaw)
        else $error("freeze kept after stop");
    a_thaw_cause: assert property (
        $fell(time_frozen) && !$past(rst) |-> stop_age <= 4'h8)
        else $error("freeze dropped without stop");
    a_drive_bounded: assert property (low_run <= 7'h48)
        else $error("sda held low too long");
endmodule
bind rtc_calendar rtc_calendar_checker i_chk (.mclk(mclk), .rst(rst), .osc_1hz(osc_1hz),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .time_frozen(time_frozen));
`default_nettype wire

// file: testbench/rtc_host_model.sv
`include "rtc_defines.vh"
`default_nettype none
module rtc_host_model (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic all_ack = 1'b1;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // A quarter of the 400 ns bit; SCL stays high between frames.
    task automatic q;
        repeat (2) @(negedge mclk);
    endtask
    task automatic start_c;
        sda_low = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic stop_c;
        sda_low = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b0;
        q;
    endtask
    task automatic bit_c(input logic b, output logic s);
        sda_low = !b;
        q;
        scl = 1'b1;
        q;
        s = sda;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic byte_c(input logic [7:0] b, input logic last, output logic [7:0] r,
                          output logic s);
        for (int i = 7; i >= 0; i--) bit_c(b[i], r[i]);
        bit_c(last, s);
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        logic s;
        byte_c(b, 1'b1, r, s);
        if (s !== 1'b0) all_ack = 1'b0;
    endtask
    // Seconds through years move in one transaction so no rollover splits them.
    task automatic write_regs(input logic [55:0] t);
        start_c;
        send({`RTC_I2C_ADDR, 1'b0});
        send({4'h0, `RTC_REG_SEC});
        for (int i = 0; i < 7; i++) send(t[55 - 8 * i -: 8]);
        stop_c;
    endtask
    task automatic read_regs(output logic [55:0] t);
        logic s;
        start_c;
        send({`RTC_I2C_ADDR, 1'b0});
        send({4'h0, `RTC_REG_SEC});
        start_c;
        send({`RTC_I2C_ADDR, 1'b1});
        for (int i = 0; i < 7; i++) byte_c(8'hFF, i == 6, t[55 - 8 * i -: 8], s);
        stop_c;
    endtask
    task automatic probe(input logic [7:0] a, output logic ack);
        logic [7:0] r;
        logic s;
        start_c;
        byte_c(a, 1'b1, r, s);
        ack = (s === 1'b0);
        stop_c;
    endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [55:0] corner [0:5] = '{56'h59_59_23_28_06_02_04,
        56'h59_59_23_28_03_02_03, 56'h59_59_23_29_02_02_00, 56'h59_59_23_31_05_12_99,
        56'h59_59_23_30_01_04_21, 56'h59_59_23_31_04_81_21};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic osc_1hz = 1'b0;
    logic [15:0] lfsr = 16'h76A3;
    int bad_count = 0;
    int tests_run = 0;
    wire scl_w;
    wire host_low;
    wire sda_w;
    wire sda_out;
    wire sda_oe_n;
    wire time_frozen;
    // Open-drain line with a pull-up: low whenever either side pulls.
    assign sda_w = (!sda_oe_n || host_low) ? 1'b0 : 1'b1;
    always #25 mclk = ~mclk;
    rtc_calendar i_rtc_calendar (.mclk(mclk), .rst(rst), .osc_1hz(osc_1hz), .scl_in(scl_w),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .time_frozen(time_frozen));
    rtc_host_model u_host (.mclk(mclk), .sda(sda_w), .scl(scl_w), .sda_low(host_low));
    function automatic int rnd(input int n);
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr % n;
    endfunction
    function automatic logic [7:0] to_bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    function automatic logic [7:0] last_day(input logic [7:0] mo, input logic [7:0] y);
        int yv;
        yv = y[7:4] * 10 + y[3:0];
        if (mo[4:0] == 5'h02) return (yv % 4 == 0) ? 8'h29 : 8'h28;
        if (mo[4:0] inside {5'h04, 5'h06, 5'h09, 5'h11}) return 8'h30;
        return 8'h31;
    endfunction
    function automatic logic [55:0] rtc_inc(input logic [55:0] t);
        logic [7:0] s, mi, h, d, w, mo, y;
        {s, mi, h, d, w, mo, y} = t;
        if (s[6:0] != 7'h59) return {bcd_inc(s), t[47:0]};
        s = {s[7], 7'h00};
        if (mi != 8'h59) return {s, bcd_inc(mi), t[39:0]};
        if (h != 8'h23) return {s, 8'h00, bcd_inc(h), t[31:0]};
        w = (w == 8'h06) ? 8'h00 : w + 8'h01;
        if (d != last_day(mo, y)) return {s, 16'h0000, bcd_inc(d), w, mo, y};
        if (mo[4:0] != 5'h12) return {s, 16'h0000, 8'h01, w, bcd_inc(mo), y};
        if (y != 8'h99) return {s, 16'h0000, 8'h01, w, mo[7], 7'h01, bcd_inc(y)};
        return {s, 16'h0000, 8'h01, w, ~mo[7], 7'h01, 8'h00};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic check_all(input logic [55:0] seen, input logic [55:0] exp);
        for (int i = 6; i >= 0; i--) begin
            check($sformatf("reg %0d", 8 - i), seen[8 * i +: 8], exp[8 * i +: 8]);
        end
    endtask
    task automatic tick;
        osc_1hz = 1'b1;
        repeat (10) @(negedge mclk);
        osc_1hz = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
    task automatic run_case(input logic [55:0] t, input logic adv);
        logic [55:0] got;
        u_host.write_regs(t);
        if (adv) tick;
        u_host.read_regs(got);
        check_all(got, adv ? rtc_inc(t) : t);
    endtask
    task automatic stop_test;
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        logic [55:0] got;
        logic [55:0] t;
        logic [7:0] mo;
        logic [7:0] y;
        logic ack;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        u_host.read_regs(got);
        check_all(got, 56'h80_00_00_01_00_01_00);
        $display("test reset_values done");
        foreach (corner[i]) run_case(corner[i], 1'b1);
        $display("test calendar_rollover done");
        for (int i = 0; i < 8; i++) begin
            y = to_bcd(rnd(100));
            mo = to_bcd(1 + rnd(12));
            t = {to_bcd(rnd(2) ? 59 : rnd(60)), to_bcd(rnd(2) ? 59 : rnd(60)),
                to_bcd(rnd(2) ? 23 : rnd(24)), rnd(2) ? last_day(mo, y) : to_bcd(1 + rnd(28)),
                to_bcd(rnd(7)), rnd(2) ? mo | 8'h80 : mo, y};
            run_case(t, i % 4 != 0);
        end
        $display("test random_dates done");
        t = 56'h59_59_23_31_06_12_99;
        u_host.write_regs(t);
        fork
            u_host.read_regs(got);
            begin
                repeat (200) @(negedge mclk);
                tick;
            end
        join
        check_all(got, t);
        u_host.read_regs(got);
        check_all(got, rtc_inc(t));
        $display("test freeze_replay done");
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        u_host.read_regs(got);
        check_all(got, 56'h80_00_00_01_00_01_00);
        $display("test mid_reset done");
        // Unused bits are written high and must read back as zero; the
        // integrity flag is set by the write and must survive the tick.
        u_host.write_regs(56'hD9_D9_E3_F1_FE_72_45);
        tick;
        u_host.read_regs(got);
        check_all(got, rtc_inc(56'hD9_59_23_31_06_12_45));
        $display("test unused_bits done");
        u_host.probe(8'hA4, ack);
        check("foreign ack", {7'h00, ack}, 8'h00);
        check("frozen", {7'h00, time_frozen}, 8'h00);
        check("host acks", {7'h00, u_host.all_ack}, 8'h01);
        $display("test foreign_address done");
        stop_test;
    end
    // About 36 transactions of under 750 cycles each; allow over twice that.
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        stop_test;
    end
endmodule
`default_nettype wire
